/* File: uap_pkg.sv */
// Package for the addressed serial poll filter: register map, field layout, modes, timing, stream carrier
package uap_pkg;

  // Timing: the millisecond unit of every configured delay
  localparam int CLK_FREQ_MHZ = 50;
  localparam int MS_UNIT_US = 1000;
  localparam int MS_CYCLES = CLK_FREQ_MHZ * MS_UNIT_US;

  // Register offsets, byte addresses of aligned words
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_POS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_CTS_PRE = 8'h0C;
  localparam logic [7:0] REG_CTS_POST = 8'h10;
  localparam logic [7:0] REG_BC_DELAY = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;

  // Control register field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_POLL_BIT = 2;
  localparam int CTRL_ENV_BIT = 3;
  localparam int CTRL_FLOW_BIT = 4;

  // Status register field positions
  localparam int STAT_VALID_BIT = 16;
  localparam int STAT_SHORT_BIT = 17;
  localparam int STAT_ARMED_BIT = 18;
  localparam int STAT_CTS_BIT = 19;

  // Address formats
  typedef enum logic [1:0] {
    UAP_MODE_BIN1 = 2'b00,
    UAP_MODE_ASCII2 = 2'b01,
    UAP_MODE_BIN2_LSB = 2'b10,
    UAP_MODE_BIN2_MSB = 2'b11
  } uap_mode_type;

  // Reset values
  localparam logic [1:0] RST_MODE = 2'b00;
  localparam logic RST_POLL = 1'b1;
  localparam logic RST_ENV = 1'b0;
  localparam logic RST_FLOW = 1'b0;
  localparam logic [15:0] RST_POS = 16'h0001;
  localparam logic [15:0] RST_MASK = 16'hFFFF;
  localparam logic [15:0] RST_MS = 16'h0000;

  // One byte of a serial stream with its framing marks
  typedef struct packed {
    logic valid;
    logic sof;
    logic eom;
    logic [7:0] data;
  } uap_byte_type;

endpackage

/* File: uap_filter.sv */
// Addressed serial poll filter: address pick-up, poll response filter, CTS envelope, broadcast delay
`timescale 1ns/1ps

// What this block does
// - Request bytes pass through complete and unaltered; address is only read.
// - Address format: one binary byte, two ASCII, two binary LSB or MSB first.
// - ASCII format: two hex characters form one byte, first is upper nibble.
// - Address position counts from one; one selects the first byte.
// - Two-byte binary value built in chosen order, ANDed with mask, passed on.
// - LSB-first: byte at position is low byte, next byte is high byte.
// - Address mask resets to FFFF so full two-byte value is used.
// - Filter on by default: one reply per request, only from polled remote.
// - Late reply from an earlier slave is dropped; wait continues for current one.
// - Filter off: every radio packet, broadcasts too, is forwarded unchecked.
// - CTS envelope off by default and inactive while flow control is on.
// - CTS rises configured milliseconds before serial data starts.
// - CTS held configured milliseconds after last serial byte, then dropped.
// - Legacy network transmissions held back by the broadcast delay.
module uap_filter #(
  parameter int MS_CYCLES = uap_pkg::MS_CYCLES,
  parameter int CNT_W = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire uap_pkg::uap_byte_type req_i,
  output uap_pkg::uap_byte_type req_o,
  output logic addr_valid_o,
  output logic [15:0] addr_o,
  output logic addr_short_o,
  input wire uap_pkg::uap_byte_type rsp_i,
  input wire logic [15:0] rsp_src_i,
  input wire logic rsp_bcast_i,
  output uap_pkg::uap_byte_type rsp_o,
  input wire uap_pkg::uap_byte_type tx_i,
  output logic tx_ready_o,
  output uap_pkg::uap_byte_type ser_o,
  output logic cts_o,
  input wire uap_pkg::uap_byte_type leg_i,
  output logic leg_ready_o,
  output uap_pkg::uap_byte_type leg_o
);

  typedef enum logic [1:0] {
    UAP_ENV_IDLE = 2'b00,
    UAP_ENV_PRE = 2'b01,
    UAP_ENV_SEND = 2'b10,
    UAP_ENV_POST = 2'b11
  } uap_env_type;
  typedef enum logic [1:0] {
    UAP_LEG_IDLE = 2'b00,
    UAP_LEG_WAIT = 2'b01,
    UAP_LEG_PASS = 2'b10
  } uap_leg_type;

  localparam logic [31:0] DIV_LAST = 32'(MS_CYCLES - 1);
  // Hex character to nibble; a non-hex character reads as zero
  function automatic logic [3:0] hex_nib(input logic [7:0] c);
    logic [3:0] n;
    n = 4'h0;
    if (c >= 8'h30 && c <= 8'h39) begin
      n = 4'(c - 8'h30);
    end else if (c >= 8'h41 && c <= 8'h46) begin
      n = 4'(c - 8'h37);
    end else if (c >= 8'h61 && c <= 8'h66) begin
      n = 4'(c - 8'h57);
    end
    return n;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [1:0] mode_r;
  logic poll_en_r;
  logic env_en_r;
  logic flow_en_r;
  logic [15:0] pos_r;
  logic [15:0] mask_r;
  logic [15:0] pre_ms_r;
  logic [15:0] post_ms_r;
  logic [15:0] bc_ms_r;
  logic [31:0] rdata_r;
  wire logic wr_ctrl = reg_wr_i && reg_addr_i == uap_pkg::REG_CTRL;
  wire logic wr_pos = reg_wr_i && reg_addr_i == uap_pkg::REG_POS;
  wire logic wr_mask = reg_wr_i && reg_addr_i == uap_pkg::REG_MASK;
  wire logic wr_pre = reg_wr_i && reg_addr_i == uap_pkg::REG_CTS_PRE;
  wire logic wr_post = reg_wr_i && reg_addr_i == uap_pkg::REG_CTS_POST;
  wire logic wr_bc = reg_wr_i && reg_addr_i == uap_pkg::REG_BC_DELAY;

  // Register writes; defaults give one-byte mode, filter on, envelope off, full mask
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_r <= uap_pkg::RST_MODE;
      poll_en_r <= uap_pkg::RST_POLL;
      env_en_r <= uap_pkg::RST_ENV;
      flow_en_r <= uap_pkg::RST_FLOW;
      pos_r <= uap_pkg::RST_POS;
      mask_r <= uap_pkg::RST_MASK;
      pre_ms_r <= uap_pkg::RST_MS;
      post_ms_r <= uap_pkg::RST_MS;
      bc_ms_r <= uap_pkg::RST_MS;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        mode_r <= reg_wdata_i[uap_pkg::CTRL_MODE_LSB +: 2];
        poll_en_r <= reg_wdata_i[uap_pkg::CTRL_POLL_BIT];
        env_en_r <= reg_wdata_i[uap_pkg::CTRL_ENV_BIT];
        flow_en_r <= reg_wdata_i[uap_pkg::CTRL_FLOW_BIT];
      end
      if (wr_pos) pos_r <= reg_wdata_i[15:0];
      if (wr_mask) mask_r <= reg_wdata_i[15:0];
      if (wr_pre) pre_ms_r <= reg_wdata_i[15:0];
      if (wr_post) post_ms_r <= reg_wdata_i[15:0];
      if (wr_bc) bc_ms_r <= reg_wdata_i[15:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address pick-up from the request stream
  logic [CNT_W-1:0] cnt_r;
  logic [7:0] b0_r;
  logic done_r;
  logic armed_r;
  logic [15:0] polled_r;
  logic addr_valid_r;
  logic [15:0] addr_r;
  logic short_r;
  logic last_valid_r;
  logic last_short_r;
  // Position of the incoming byte, one for the first byte of a message
  wire logic [CNT_W-1:0] byte_no = req_i.sof ? CNT_W'(1) : cnt_r + CNT_W'(1);
  wire logic two_byte = mode_r != uap_pkg::UAP_MODE_BIN1;
  wire logic [CNT_W-1:0] pos_w = CNT_W'(pos_r);
  wire logic at_first = req_i.valid && byte_no == pos_w && pos_w != '0;
  wire logic at_last = req_i.valid && !(req_i.sof ? 1'b0 : done_r) &&
                       (two_byte ? (pos_w != '0 && byte_no == pos_w + CNT_W'(1)) : at_first);
  wire logic [7:0] first_b = at_first ? req_i.data : b0_r;
  // Assemble the address for every format
  wire logic [15:0] addr_bin1 = {8'h00, req_i.data};
  wire logic [15:0] addr_asc = {8'h00, hex_nib(first_b), hex_nib(req_i.data)};
  wire logic [15:0] addr_lsb = {req_i.data, first_b} & mask_r;
  wire logic [15:0] addr_msb = {first_b, req_i.data} & mask_r;
  wire logic [15:0] addr_sel = mode_r == uap_pkg::UAP_MODE_BIN1 ? addr_bin1 :
                               mode_r == uap_pkg::UAP_MODE_ASCII2 ? addr_asc :
                               mode_r == uap_pkg::UAP_MODE_BIN2_LSB ? addr_lsb : addr_msb;
  wire logic short_now = req_i.valid && req_i.eom && !at_last && !(req_i.sof ? 1'b0 : done_r);
  // Byte counter, captured first byte and address results
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= '0;
      b0_r <= 8'h00;
      done_r <= 1'b0;
      addr_valid_r <= 1'b0;
      addr_r <= 16'h0000;
      short_r <= 1'b0;
      polled_r <= 16'h0000;
      last_valid_r <= 1'b0;
      last_short_r <= 1'b0;
    end else if (ce_i) begin
      addr_valid_r <= at_last;
      short_r <= short_now;
      if (req_i.valid) begin
        cnt_r <= byte_no;
        if (req_i.sof) done_r <= 1'b0;
        if (at_first) b0_r <= req_i.data;
        if (at_last) begin
          done_r <= 1'b1;
          addr_r <= addr_sel;
          polled_r <= addr_sel;
          last_valid_r <= 1'b1;
          last_short_r <= 1'b0;
        end else if (short_now) begin
          last_valid_r <= 1'b0;
          last_short_r <= 1'b1;
        end
      end
    end
  end

  // Request bytes pass through one cycle later, untouched
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_o <= '0;
    end else if (ce_i) begin
      req_o <= req_i;
    end
  end

  assign addr_valid_o = addr_valid_r;
  assign addr_o = addr_r;
  assign addr_short_o = short_r;

  //////////////////////////////////////////////////////////////////////////////
  // Poll response filter on the radio side
  logic pass_r;
  wire logic match = armed_r && !rsp_bcast_i && rsp_src_i == polled_r;
  wire logic pass_sof = !poll_en_r || match;
  wire logic pass_now = rsp_i.sof ? pass_sof : (pass_r || !poll_en_r);
  wire logic fwd = rsp_i.valid && pass_now;
  wire logic reply_end = fwd && rsp_i.eom && poll_en_r;
  // Arm on each new request address; one accepted reply disarms; new request wins
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      armed_r <= 1'b0;
      pass_r <= 1'b0;
      rsp_o <= '0;
    end else if (ce_i) begin
      if (at_last) begin
        armed_r <= 1'b1;
      end else if (reply_end) begin
        armed_r <= 1'b0;
      end
      if (rsp_i.valid && rsp_i.sof) pass_r <= pass_sof;
      rsp_o <= fwd ? rsp_i : '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // CTS envelope around serial output
  uap_env_type env_r;
  uap_env_type env_nxt;
  logic [31:0] ediv_r;
  logic [15:0] ems_r;
  wire logic env_act = env_en_r && !flow_en_r;
  wire logic etick = ediv_r == DIV_LAST;
  wire logic pre_done = ems_r >= pre_ms_r;
  wire logic post_done = ems_r >= post_ms_r;
  wire logic tx_take = tx_i.valid && tx_ready_o;

  // Envelope next state
  always_comb begin
    env_nxt = env_r;
    unique case (env_r)
      UAP_ENV_IDLE: begin
        if (env_act && tx_i.valid) env_nxt = pre_ms_r == 16'h0000 ? UAP_ENV_SEND : UAP_ENV_PRE;
      end
      UAP_ENV_PRE: begin
        if (pre_done) env_nxt = UAP_ENV_SEND;
      end
      UAP_ENV_SEND: begin
        if (tx_take && tx_i.eom) env_nxt = UAP_ENV_POST;
      end
      UAP_ENV_POST: begin
        if (tx_i.valid) env_nxt = UAP_ENV_SEND;
        else if (post_done) env_nxt = UAP_ENV_IDLE;
      end
    endcase
    if (!env_act) env_nxt = UAP_ENV_IDLE;
  end

  // Envelope state and millisecond timer, restarted on each phase change
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      env_r <= UAP_ENV_IDLE;
      ediv_r <= 32'h00000000;
      ems_r <= 16'h0000;
    end else if (ce_i) begin
      env_r <= env_nxt;
      if (env_nxt != env_r) begin
        ediv_r <= 32'h00000000;
        ems_r <= 16'h0000;
      end else if (etick) begin
        ediv_r <= 32'h00000000;
        if (ems_r != 16'hFFFF) ems_r <= ems_r + 16'h0001;
      end else begin
        ediv_r <= ediv_r + 32'h00000001;
      end
    end
  end

  // Data flows only once the lead time is over; bypass when inactive
  assign tx_ready_o = !env_act || env_r == UAP_ENV_SEND || env_r == UAP_ENV_POST;
  assign cts_o = env_r != UAP_ENV_IDLE;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ser_o <= '0;
    end else if (ce_i) begin
      ser_o <= tx_take ? tx_i : '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Broadcast delay toward the legacy network
  uap_leg_type leg_r;
  uap_leg_type leg_nxt;
  logic [31:0] ldiv_r;
  logic [15:0] lms_r;
  wire logic ltick = ldiv_r == DIV_LAST;
  wire logic leg_take = leg_i.valid && leg_ready_o;

  // Legacy path next state
  always_comb begin
    leg_nxt = leg_r;
    unique case (leg_r)
      UAP_LEG_IDLE: begin
        if (leg_i.valid) leg_nxt = bc_ms_r == 16'h0000 ? UAP_LEG_PASS : UAP_LEG_WAIT;
      end
      UAP_LEG_WAIT: begin
        if (lms_r >= bc_ms_r) leg_nxt = UAP_LEG_PASS;
      end
      UAP_LEG_PASS: begin
        if (leg_take && leg_i.eom) leg_nxt = UAP_LEG_IDLE;
      end
      default: leg_nxt = UAP_LEG_IDLE;
    endcase
  end

  // Legacy state and its millisecond timer
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      leg_r <= UAP_LEG_IDLE;
      ldiv_r <= 32'h00000000;
      lms_r <= 16'h0000;
    end else if (ce_i) begin
      leg_r <= leg_nxt;
      if (leg_nxt != leg_r) begin
        ldiv_r <= 32'h00000000;
        lms_r <= 16'h0000;
      end else if (ltick) begin
        ldiv_r <= 32'h00000000;
        if (lms_r != 16'hFFFF) lms_r <= lms_r + 16'h0001;
      end else begin
        ldiv_r <= ldiv_r + 32'h00000001;
      end
    end
  end

  assign leg_ready_o = leg_r == UAP_LEG_PASS;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      leg_o <= '0;
    end else if (ce_i) begin
      leg_o <= leg_take ? leg_i : '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read-back; unmapped offsets read zero
  wire logic [31:0] ctrl_rd = {27'h0000000, flow_en_r, env_en_r, poll_en_r, mode_r};
  wire logic [31:0] stat_rd = {12'h000, cts_o, armed_r, last_short_r, last_valid_r, polled_r};
  wire logic [31:0] rd_mux = reg_addr_i == uap_pkg::REG_CTRL ? ctrl_rd :
                             reg_addr_i == uap_pkg::REG_POS ? {16'h0000, pos_r} :
                             reg_addr_i == uap_pkg::REG_MASK ? {16'h0000, mask_r} :
                             reg_addr_i == uap_pkg::REG_CTS_PRE ? {16'h0000, pre_ms_r} :
                             reg_addr_i == uap_pkg::REG_CTS_POST ? {16'h0000, post_ms_r} :
                             reg_addr_i == uap_pkg::REG_BC_DELAY ? {16'h0000, bc_ms_r} :
                             reg_addr_i == uap_pkg::REG_STATUS ? stat_rd : 32'h00000000;

  // Read data stands one cycle after the strobe and only then
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_r <= 32'h00000000;
    end else if (ce_i) begin
      rdata_r <= reg_rd_i ? rd_mux : 32'h00000000;
    end
  end

  assign reg_rdata_o = rdata_r;

endmodule

/* File: uap_filter_monitor.sv */
// Port checker for the poll filter
`timescale 1ns/1ps
module uap_filter_monitor #(
  parameter int MS_CYCLES = 4
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire uap_pkg::uap_byte_type req_i,
  input wire uap_pkg::uap_byte_type req_o,
  input wire logic addr_valid_o,
  input wire logic [15:0] addr_o,
  input wire logic addr_short_o,
  input wire uap_pkg::uap_byte_type rsp_i,
  input wire uap_pkg::uap_byte_type rsp_o,
  input wire uap_pkg::uap_byte_type tx_i,
  input wire logic tx_ready_o,
  input wire uap_pkg::uap_byte_type ser_o,
  input wire logic cts_o,
  input wire uap_pkg::uap_byte_type leg_i,
  input wire logic leg_ready_o
);
  logic [4:0] ctrl_r;
  logic [15:0] mask_r;
  logic [15:0] pre_r;
  logic [15:0] post_r;
  logic [15:0] bc_r;
  wire env_on;
  ////////////////////////////////////////////////////////////
  // Shadow of the configuration written by software
  assign env_on = ctrl_r[3] && !ctrl_r[4];
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r <= 5'h04;
      mask_r <= 16'hFFFF;
      pre_r <= 16'h0000;
      post_r <= 16'h0000;
      bc_r <= 16'h0000;
    end else if (reg_wr_i && ce_i) begin
      if (reg_addr_i == uap_pkg::REG_CTRL) ctrl_r <= reg_wdata_i[4:0];
      if (reg_addr_i == uap_pkg::REG_MASK) mask_r <= reg_wdata_i[15:0];
      if (reg_addr_i == uap_pkg::REG_CTS_PRE) pre_r <= reg_wdata_i[15:0];
      if (reg_addr_i == uap_pkg::REG_CTS_POST) post_r <= reg_wdata_i[15:0];
      if (reg_addr_i == uap_pkg::REG_BC_DELAY) bc_r <= reg_wdata_i[15:0];
    end
  end
  ////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence s_tx_take;
    tx_i.valid && tx_ready_o;
  endsequence
  sequence s_cts_rise;
    $rose(cts_o) && env_on && pre_r != 16'h0000;
  endsequence
  sequence s_hold_off;
    !tx_ready_o [*3];
  endsequence
  chk_req_copy: assert property (ce_i && req_i.valid |=> req_o == $past(req_i))
    else $error("request byte altered");
  chk_short_excl: assert property (addr_short_o |-> !addr_valid_o)
    else $error("short and address together");
  chk_mask_and: assert property (addr_valid_o && ctrl_r[1] |-> (addr_o & ~mask_r) == 16'h0000)
    else $error("mask not applied");
  chk_byte_narrow: assert property (addr_valid_o && !ctrl_r[1] |-> addr_o[15:8] == 8'h00)
    else $error("one-byte address too wide");
  chk_rsp_idle: assert property (!rsp_i.valid |=> rsp_o == 11'h000)
    else $error("response output not idle");
  chk_rsp_open: assert property (!ctrl_r[2] && !$past(ctrl_r[2]) && rsp_i.valid |=> rsp_o == $past(rsp_i))
    else $error("unfiltered reply not passed");
  chk_env_idle: assert property (!env_on && !$past(env_on) |-> !cts_o && tx_ready_o)
    else $error("envelope active while off");
  chk_cts_take: assert property (env_on && $past(env_on) ##0 s_tx_take |-> cts_o)
    else $error("byte sent without cts");
  chk_cts_pre: assert property (s_cts_rise |-> s_hold_off)
    else $error("pre time too short");
  chk_cts_post: assert property ($fell(cts_o) && $past(env_on) && post_r != 16'h0000 |->
    !$past(ser_o.valid) && !$past(ser_o.valid, 2)) else $error("post time too short");
  chk_ser_copy: assert property (s_tx_take |=> ser_o == $past(tx_i))
    else $error("serial byte altered");
  chk_leg_hold: assert property ($rose(leg_i.valid) && bc_r != 16'h0000 |-> !leg_ready_o [*3])
    else $error("legacy byte not delayed");
endmodule
bind uap_filter uap_filter_monitor #(.MS_CYCLES(MS_CYCLES)) i_uap_filter_monitor (.clk_sys_i, .rst_b_i, .ce_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .req_i, .req_o, .addr_valid_o, .addr_o, .addr_short_o, .rsp_i,
  .rsp_o, .tx_i, .tx_ready_o, .ser_o, .cts_o, .leg_i, .leg_ready_o);

/* File: uap_app_model.sv */
// Master application model feeding request messages
`timescale 1ns/1ps
module uap_app_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [31:0] msg_i,
  input wire logic [2:0] len_i,
  output uap_pkg::uap_byte_type req_o
);
  logic [2:0] idx_r = 3'h0;
  logic [31:0] sh;
  // One byte a cycle once go is seen
  always @(posedge clk_i) begin
    if (go_i && idx_r == 3'h0) begin
      idx_r <= 3'h1;
    end else if (idx_r != 3'h0 && idx_r < len_i) begin
      idx_r <= idx_r + 3'h1;
    end else begin
      idx_r <= 3'h0;
    end
  end
  // Byte idx is taken from the message word, most significant byte first
  assign sh = msg_i << (8 * (idx_r - 3'h1));
  // Idle line shows the inverse of the message word's low byte
  assign req_o = (idx_r != 3'h0) ? {1'b1, idx_r == 3'h1, idx_r == len_i, sh[31:24]} : {3'b000, ~msg_i[7:0]};
endmodule

/* File: uap_filter_tb.sv */
// Self-checking bench for the poll filter
`timescale 1ns/1ps
module uap_filter_tb;
  typedef struct packed {
    logic [1:0] mode;
    logic [7:0] pos;
    logic [15:0] mask;
    logic [31:0] msg;
    logic [2:0] len;
    logic [16:0] exp;
  } uap_row_type;
  localparam int MSC = 4;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  uap_pkg::uap_byte_type req_i, req_o, rsp_o, ser_o, leg_o;
  uap_pkg::uap_byte_type rsp_i = '0;
  uap_pkg::uap_byte_type tx_i = '0;
  uap_pkg::uap_byte_type leg_i = '0;
  logic [15:0] rsp_src_i = 16'h0;
  logic rsp_bcast_i = 1'b0;
  logic addr_valid_o, addr_short_o, tx_ready_o, cts_o, leg_ready_o;
  logic [15:0] addr_o;
  logic go = 1'b0;
  logic [31:0] msg = 32'h0;
  logic [2:0] len = 3'h0;
  int failures = 0;
  int checks_done = 0;
  logic [31:0] d;
  logic [15:0] a;
  logic s;
  logic [8:0] g;
  int n;
  uap_row_type rows [6] = '{'{2'h0, 8'h01, 16'hFFFF, 32'h5A112233, 3'h4, 17'h0005A},
    '{2'h1, 8'h02, 16'hFFFF, 32'h00414200, 3'h4, 17'h000AB},
    '{2'h3, 8'h03, 16'h0FFF, 32'h02DA92C3, 3'h4, 17'h002C3},
    '{2'h0, 8'h04, 16'hFFFF, 32'h11220000, 3'h2, 17'h10000},
    '{2'h2, 8'h04, 16'hFFFF, 32'h11223344, 3'h4, 17'h10000},
    '{2'h2, 8'h02, 16'h7FF0, 32'h02DA92C3, 3'h4, 17'h012D0}};
  logic [7:0] radr [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
  logic [31:0] rexp [8] = '{32'h4, 32'h1, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  uap_filter #(.MS_CYCLES(MSC)) i_uap_filter (.clk_sys_i, .rst_b_i, .ce_i(1'b1), .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .req_i, .req_o, .addr_valid_o, .addr_o, .addr_short_o, .rsp_i,
    .rsp_src_i, .rsp_bcast_i, .rsp_o, .tx_i, .tx_ready_o, .ser_o, .cts_o, .leg_i, .leg_ready_o, .leg_o);
  uap_app_model i_uap_app_model (.clk_i(clk_sys_i), .go_i(go), .msg_i(msg), .len_i(len), .req_o(req_i));
  ////////////////////////////////////////////////////////////
  // Clock
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  ////////////////////////////////////////////////////////////
  // Tasks
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task results;
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk_sys_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, ad, wd};
    @(posedge clk_sys_i) reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] ad, output logic [31:0] rdv);
    @(posedge clk_sys_i) {reg_rd_i, reg_addr_i} <= {1'b1, ad};
    @(posedge clk_sys_i) reg_rd_i <= 1'b0;
    @(negedge clk_sys_i) rdv = reg_rdata_o;
  endtask
  task send_msg(input logic [31:0] m, input logic [2:0] l);
    @(posedge clk_sys_i) {go, msg, len} <= {1'b1, m, l};
    @(posedge clk_sys_i) go <= 1'b0;
    for (n = 0; n < 12 && !(addr_valid_o || addr_short_o); n++) @(negedge clk_sys_i);
    if (n == 12) begin
      failures++;
      results;
    end
    {a, s} = {addr_o, addr_short_o};
    repeat (4) @(posedge clk_sys_i);
  endtask
  task rsp(input logic [15:0] src, input logic bc, input logic [7:0] dt);
    @(posedge clk_sys_i) {rsp_i, rsp_src_i, rsp_bcast_i} <= {3'b111, dt, src, bc};
    @(posedge clk_sys_i) {rsp_i, rsp_src_i} <= {3'b000, ~dt, ~src};
    @(negedge clk_sys_i) g = {rsp_o.valid, rsp_o.data};
  endtask
  // Offer one byte to the serial or legacy side and count the wait
  task hs(input logic sel);
    @(posedge clk_sys_i) if (sel) leg_i <= 11'h7A5; else tx_i <= 11'h7A5;
    for (n = 0; n < 40; n++) begin
      @(negedge clk_sys_i);
      if (sel ? leg_ready_o : tx_ready_o) break;
    end
    if (n == 40) begin
      failures++;
      results;
    end
    @(posedge clk_sys_i) {leg_i, tx_i} <= 22'h0;
    @(negedge clk_sys_i) check(sel ? leg_o : ser_o, 32'h7A5);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    wr(uap_pkg::REG_STATUS, 32'hFFFFFFFF);
    wr(8'h1C, 32'hFFFFFFFF);
    for (int i = 0; i < 8; i++) begin
      rd(radr[i], d);
      check(d, rexp[i]);
    end
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      wr(uap_pkg::REG_CTRL, 32'h4 | rows[i].mode);
      wr(uap_pkg::REG_POS, {24'h0, rows[i].pos});
      wr(uap_pkg::REG_MASK, {16'h0, rows[i].mask});
      send_msg(rows[i].msg, rows[i].len);
      check({15'h0, s, s ? 16'h0 : a}, {15'h0, rows[i].exp});
    end
    rd(uap_pkg::REG_STATUS, d);
    check(d, 32'h000512D0);
    $display("test address table done");
    rsp(16'h02C3, 1'b0, 8'h3C);
    check({23'h0, g}, 32'h0);
    rsp(16'h12D0, 1'b0, 8'h3C);
    check({23'h0, g}, 32'h13C);
    rsp(16'h12D0, 1'b0, 8'h3D);
    check({23'h0, g}, 32'h0);
    wr(uap_pkg::REG_CTRL, 32'h0);
    rsp(16'h0007, 1'b1, 8'h77);
    check({23'h0, g}, 32'h177);
    $display("test reply filter done");
    wr(uap_pkg::REG_CTS_PRE, 32'h1);
    wr(uap_pkg::REG_CTS_POST, 32'h1);
    wr(uap_pkg::REG_CTRL, 32'h8);
    hs(1'b0);
    check(n >= MSC, 32'h1);
    for (n = 0; n < 40 && cts_o === 1'b1; n++) @(negedge clk_sys_i);
    check(n >= MSC && n < 40, 32'h1);
    wr(uap_pkg::REG_CTRL, 32'h18);
    hs(1'b0);
    check({n == 0, cts_o}, 32'h2);
    $display("test envelope done");
    wr(uap_pkg::REG_BC_DELAY, 32'h1);
    hs(1'b1);
    check(n >= MSC, 32'h1);
    $display("test legacy delay done");
    @(posedge clk_sys_i) rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rd(uap_pkg::REG_CTRL, d);
    check(d, 32'h4);
    $display("test second reset done");
    results;
  end
endmodule
